/* File: inc/ddac_regs.vh */
`ifndef DDAC_REGS_VH
`define DDAC_REGS_VH
// Control word fields on channel A data bits
`define DDAC_CW_PD_BIT 9
`define DDAC_CW_EN_BIT 8
`define DDAC_CW_IL_BIT 7
`define DDAC_CW_REFDIS_BIT 6
`define DDAC_CW_GAIN_HI 5
`define DDAC_CW_GAIN_LO 2
// Word bits 1:0 are dropped, so ctrl_q bit 0 is port bit 2
`define DDAC_CW_SHIFT 2
// Idle levels of strobe, select, diff pos, diff neg, single-ended clock
`define DDAC_PIN_IDLE 5'h1A
// Power-up control word: enabled, internal reference, no interleave, 0 dB
`define DDAC_CW_RESET 8'h48
`define DDAC_GAIN_ZERO 4'h8
// Power modes
`define DDAC_MODE_NORMAL 2'h0
`define DDAC_MODE_STANDBY 2'h1
`define DDAC_MODE_PDOWN 2'h2
// Wake-up from standby or power-down
`define DDAC_WAKE_NS 3000
`define DDAC_CLK_PERIOD_NS 5
`endif

/* File: rtl/ddac_sync2.v */
`timescale 1ns/10ps
`default_nettype none
module ddac_sync2 #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_q <= RST_VAL;
      q <= RST_VAL;
    end else if (ce) begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // ddac_sync2
`default_nettype wire

/* File: rtl/ddac_fifo.v */
`timescale 1ns/10ps
`default_nettype none
module ddac_fifo #(
  parameter W = 20,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  // Fill side
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output reg [W-1:0] out_data
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  reg [AW:0] cnt_q;
  reg ov_q;
  wire full = (cnt_q == DEPTH[AW:0]);
  wire push = in_valid && !full;
  wire pop = (!ov_q || out_ready) && (cnt_q != {(AW+1){1'b0}});
  assign in_ready = !full;
  assign out_valid = ov_q;
  always @(posedge clk_sys) begin
    if (push && ce) begin
      mem[wp_q[AW-1:0]] <= in_data;
    end
  end
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      ov_q <= 1'b0;
      out_data <= {W{1'b0}};
    end else if (ce) begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
        out_data <= mem[rp_q[AW-1:0]];
        ov_q <= 1'b1;
      end else if (out_ready) begin
        ov_q <= 1'b0;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // ddac_fifo
`default_nettype wire

/* File: rtl/ddac_front.v */
`timescale 1ns/10ps
`default_nettype none
`include "ddac_regs.vh"
module ddac_front #(
  parameter DW = 10,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3,
  parameter WAKE_CYCLES = (`DDAC_WAKE_NS + `DDAC_CLK_PERIOD_NS - 1) / `DDAC_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  // Sample ports
  input wire [DW-1:0] data_a,
  input wire [DW-1:0] data_b,
  // Control strobe
  input wire control_write_strobe_n,
  // Clock pins
  input wire diff_clock_select_n,
  input wire diff_clock_pos,
  input wire diff_clock_neg,
  input wire clk_pin_in,
  output reg clk_pin_out,
  output reg clk_pin_oe_n,
  // Reference pin
  output reg reference_drive,
  output reg reference_pin_oe_n,
  // Converter side
  output reg [DW-1:0] dac_a_q,
  output reg [DW-1:0] dac_b_q,
  output reg dac_update_q,
  output reg [3:0] gain_trim_a_q,
  output reg [1:0] power_mode_q,
  output reg outputs_valid_q,
  output reg interleave_q,
  output reg fifo_overflow_q
);
  // Pin synchronisers: channel A port
  wire [DW-1:0] a_s;
  ddac_sync2 #(.W(DW)) u_sync_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .d(data_a),
    .q(a_s)
  );

  // Pin synchronisers: channel B port
  wire [DW-1:0] b_s;
  ddac_sync2 #(.W(DW)) u_sync_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .d(data_b),
    .q(b_s)
  );

  // Strobe and clock pins reset to their idle levels, so no false edge follows reset
  wire [4:0] ctl_s;
  ddac_sync2 #(.W(5), .RST_VAL(`DDAC_PIN_IDLE)) u_sync_ctl (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .d({control_write_strobe_n, diff_clock_select_n, diff_clock_pos, diff_clock_neg,
        clk_pin_in}),
    .q(ctl_s)
  );
  wire cw_n_s = ctl_s[4];
  wire dsel_n_s = ctl_s[3];
  wire dp_s = ctl_s[2];
  wire dn_s = ctl_s[1];
  wire se_s = ctl_s[0];

  // Strobe edge detector
  reg cw_prev_q;
  wire cw_rise = cw_n_s && !cw_prev_q;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cw_prev_q <= 1'b1;
    end else if (ce) begin
      cw_prev_q <= cw_n_s;
    end
  end

  // Control word register
  reg [7:0] ctrl_q;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= `DDAC_CW_RESET;
    end else if (ce && cw_rise) begin
      ctrl_q <= a_s[DW-1:DW-8];
    end
  end
  wire pd_bit = ctrl_q[`DDAC_CW_PD_BIT-`DDAC_CW_SHIFT];
  wire en_bit = ctrl_q[`DDAC_CW_EN_BIT-`DDAC_CW_SHIFT];
  wire il_bit = ctrl_q[`DDAC_CW_IL_BIT-`DDAC_CW_SHIFT];
  wire refdis_bit = ctrl_q[`DDAC_CW_REFDIS_BIT-`DDAC_CW_SHIFT];
  wire [3:0] gain_bits = ctrl_q[`DDAC_CW_GAIN_HI-`DDAC_CW_SHIFT:`DDAC_CW_GAIN_LO-`DDAC_CW_SHIFT];

  // Power mode decode
  reg [1:0] mode_d;
  always @* begin
    if (pd_bit) begin
      mode_d = `DDAC_MODE_PDOWN;
    end else if (!en_bit) begin
      mode_d = `DDAC_MODE_STANDBY;
    end else begin
      mode_d = `DDAC_MODE_NORMAL;
    end
  end

  // Wake-up sequencer: idle, counting down, running
  localparam [1:0] WK_IDLE = 2'b00;
  localparam [1:0] WK_WAIT = 2'b01;
  localparam [1:0] WK_RUN = 2'b10;
  reg [1:0] wk_state_q;
  reg [1:0] wk_state_d;
  reg [15:0] wake_q;
  wire running = (mode_d == `DDAC_MODE_NORMAL);
  always @* begin
    case (wk_state_q)
      WK_IDLE: begin
        wk_state_d = running ? WK_WAIT : WK_IDLE;
      end
      WK_WAIT: begin
        if (!running) begin
          wk_state_d = WK_IDLE;
        end else if (wake_q == 16'h0001) begin
          wk_state_d = WK_RUN;
        end else begin
          wk_state_d = WK_WAIT;
        end
      end
      WK_RUN: begin
        wk_state_d = running ? WK_RUN : WK_IDLE;
      end
      default: begin
        wk_state_d = WK_IDLE;
      end
    endcase
  end
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wk_state_q <= WK_RUN;
      wake_q <= 16'h0000;
      outputs_valid_q <= 1'b1;
    end else if (ce) begin
      wk_state_q <= wk_state_d;
      if (wk_state_q != WK_WAIT) begin
        wake_q <= WAKE_CYCLES[15:0];
      end else begin
        wake_q <= wake_q - 16'h0001;
      end
      outputs_valid_q <= (wk_state_d == WK_RUN);
    end
  end

  // Conversion clock select and edges
  reg cclk_q;
  wire cclk = dsel_n_s ? se_s : (dp_s && !dn_s);
  wire c_rise = cclk && !cclk_q;
  wire c_fall = !cclk && cclk_q;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cclk_q <= 1'b0;
    end else if (ce) begin
      cclk_q <= cclk;
    end
  end

  // Input capture stage
  reg [DW-1:0] cap_a_q;
  reg [DW-1:0] cap_b_q;
  reg cap_v_q;
  reg il_b_q;
  wire fifo_in_ready;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cap_a_q <= {DW{1'b0}};
      cap_b_q <= {DW{1'b0}};
      cap_v_q <= 1'b0;
      il_b_q <= 1'b0;
    end else if (ce) begin
      cap_v_q <= 1'b0;
      if (il_bit) begin
        if (c_fall) begin
          cap_b_q <= a_s;
          il_b_q <= 1'b1;
        end
        if (c_rise && il_b_q) begin
          cap_a_q <= a_s;
          cap_v_q <= 1'b1;
          il_b_q <= 1'b0;
        end
      end else if (c_rise) begin
        cap_a_q <= a_s;
        cap_b_q <= b_s;
        cap_v_q <= 1'b1;
        il_b_q <= 1'b0;
      end
    end
  end

  // Interleave flag and sticky overflow flag
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      interleave_q <= 1'b0;
    end else if (ce) begin
      interleave_q <= il_bit;
    end
  end
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      fifo_overflow_q <= 1'b0;
    end else if (ce && cap_v_q && !fifo_in_ready) begin
      fifo_overflow_q <= 1'b1;
    end
  end

  // Sample buffer
  wire fifo_out_valid;
  wire [2*DW-1:0] fifo_out_data;
  wire drain = c_rise && running;
  ddac_fifo #(.W(2*DW), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(cap_v_q),
    .in_ready(fifo_in_ready),
    .in_data({cap_a_q, cap_b_q}),
    .out_valid(fifo_out_valid),
    .out_ready(drain),
    .out_data(fifo_out_data)
  );

  // Output register: previous sample released on the next rising edge
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      dac_a_q <= {DW{1'b0}};
      dac_b_q <= {DW{1'b0}};
      dac_update_q <= 1'b0;
    end else if (ce) begin
      dac_update_q <= 1'b0;
      if (drain && fifo_out_valid) begin
        dac_a_q <= fifo_out_data[2*DW-1:DW];
        dac_b_q <= fifo_out_data[DW-1:0];
        dac_update_q <= 1'b1;
      end
    end
  end

  // Gain trim and power mode outputs
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      gain_trim_a_q <= `DDAC_GAIN_ZERO;
    end else if (ce) begin
      gain_trim_a_q <= gain_bits;
    end
  end
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      power_mode_q <= `DDAC_MODE_NORMAL;
    end else if (ce) begin
      power_mode_q <= mode_d;
    end
  end

  // Clock pin replica and direction
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      clk_pin_out <= 1'b0;
    end else if (ce) begin
      clk_pin_out <= dp_s && !dn_s;
    end
  end
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      clk_pin_oe_n <= 1'b1;
    end else if (ce) begin
      clk_pin_oe_n <= dsel_n_s;
    end
  end

  // Reference enable and pin direction
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reference_drive <= 1'b1;
    end else if (ce) begin
      reference_drive <= !refdis_bit;
    end
  end
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reference_pin_oe_n <= 1'b0;
    end else if (ce) begin
      reference_pin_oe_n <= refdis_bit;
    end
  end
endmodule // ddac_front
`default_nettype wire

/* File: dv/ddac_front_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
module ddac_front_assertions #(parameter int WAKE_CYCLES = 4) (
  // Clock
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pins
  input wire logic control_write_strobe_n,
  input wire logic diff_clock_select_n,
  input wire logic clk_pin_oe_n,
  input wire logic reference_drive,
  input wire logic reference_pin_oe_n,
  // Converter
  input wire logic [9:0] dac_a_q,
  input wire logic [9:0] dac_b_q,
  input wire logic dac_update_q,
  input wire logic [3:0] gain_trim_a_q,
  input wire logic [1:0] power_mode_q,
  input wire logic outputs_valid_q
);
  localparam int WB = WAKE_CYCLES + 8;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_cw_idle; $stable(control_write_strobe_n) [*8]; endsequence
  sequence s_sel_idle; $stable(diff_clock_select_n) [*6]; endsequence
  a_word_holds: assert property (s_cw_idle |-> $stable({gain_trim_a_q, power_mode_q}))
    else $error("control moved");
  a_clk_dir: assert property (s_sel_idle |-> clk_pin_oe_n == diff_clock_select_n)
    else $error("clock pin direction");
  a_ref_pin: assert property (reference_pin_oe_n == !reference_drive)
    else $error("reference pin");
  a_upd_pulse: assert property (dac_update_q |=> !dac_update_q [*3])
    else $error("update pulse");
  a_dac_moves: assert property (!$stable({dac_a_q, dac_b_q}) |-> dac_update_q)
    else $error("output moved alone");
  a_idle_frozen: assert property (power_mode_q != 2'h0 && $past(power_mode_q) != 2'h0 |-> !dac_update_q)
    else $error("update while idle");
  a_wake_ends: assert property (!outputs_valid_q && power_mode_q == 2'h0 |-> ##[1:WB] outputs_valid_q)
    else $error("wake too long");
  a_wake_starts: assert property ($rose(power_mode_q == 2'h0) |-> ##[0:1] !outputs_valid_q)
    else $error("no wake delay");
endmodule // ddac_front_assertions
bind ddac_front ddac_front_assertions #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (.*);
`default_nettype wire

/* File: dv/ddac_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ddac_host_model (
  // Clock and mode
  input wire logic clk_sys,
  input wire logic il,
  // Pins
  output logic [9:0] data_a,
  output logic [9:0] data_b,
  output logic strobe_n,
  output logic conv
);
  logic [2:0] cs = 3'h0;
  int k = 8;
  function automatic logic [9:0] pa(input int i);
    return 10'(i * 91 + 17);
  endfunction
  function automatic logic [9:0] pb(input int i);
    return 10'(i * 199 + 546);
  endfunction
  initial begin
    data_a = 10'h3FF;
    data_b = 10'h3FF;
    strobe_n = 1'b1;
    conv = 1'b0;
    #1.3;
    forever #32 conv = ~conv;
  end
  // Data changes mid-phase, away from the capture edges
  always @(posedge clk_sys) begin
    cs <= {cs[1:0], conv};
    if (il)
      data_b <= ~data_b;
    if (k < 8 && cs[2] != cs[1])
      if (cs[1] && il)
        data_a <= pb(k);
      else if (!cs[1] && (!il || data_a == pb(k))) begin
        data_a <= pa(k);
        if (!il)
          data_b <= pb(k);
        k <= k + 1;
      end
  end
  task automatic write_word(input logic [7:0] w);
    @(posedge clk_sys);
    data_a <= {w, 2'h1};
    strobe_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    strobe_n <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule // ddac_host_model
`default_nettype wire

/* File: dv/ddac_front_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`define CMP(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module ddac_front_tb;
  logic clk_sys, rst_n, sel_n, hil, sn, conv, cpo, cpoe, upd, rdrv, roe, valid, il_q, ovf;
  logic [9:0] da, db, dac_a, dac_b;
  logic [3:0] gain;
  logic [1:0] mode;
  logic [3:0] gt [3] = '{4'h0, 4'h8, 4'hF};
  logic [7:0] mw [3] = '{8'h08, 8'hC8, 8'h88};
  logic [1:0] me [3] = '{2'h1, 2'h2, 2'h2};
  int n_errors = 0, cmp_count = 0, idx = 0, nclk = 0, n;
  ddac_host_model u_host (.clk_sys(clk_sys), .il(hil), .data_a(da), .data_b(db),
    .strobe_n(sn), .conv(conv));
  ddac_front #(.WAKE_CYCLES(20)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
    .data_a(da), .data_b(db), .control_write_strobe_n(sn), .diff_clock_select_n(sel_n),
    .diff_clock_pos(!sel_n & conv), .diff_clock_neg(!(!sel_n & conv)),
    .clk_pin_in(!cpoe ? cpo : sel_n & conv), .clk_pin_out(cpo), .clk_pin_oe_n(cpoe),
    .reference_drive(rdrv), .reference_pin_oe_n(roe), .dac_a_q(dac_a), .dac_b_q(dac_b),
    .dac_update_q(upd), .gain_trim_a_q(gain), .power_mode_q(mode), .outputs_valid_q(valid),
    .interleave_q(il_q), .fifo_overflow_q(ovf));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Pairs must come out whole and in order
  always @(posedge clk_sys) begin
    if (upd === 1'b1 && idx < 8 && dac_a === u_host.pa(idx)) begin
      `CMP(dac_b, u_host.pb(idx))
      idx <= idx + 1;
    end
    if (cpoe === 1'b0 && $rose(cpo))
      nclk++;
  end
  task automatic burst(input logic m, input logic s);
    sel_n <= s;
    hil <= m;
    idx = 0;
    repeat (30) @(posedge clk_sys);
    u_host.k = 0;
    repeat (300) @(posedge clk_sys);
    `CMP(idx, 8)
  endtask
  task automatic results;
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #20000;
    n_errors++;
    results();
  end
  initial begin
    rst_n = 1'b0;
    sel_n = 1'b1;
    hil = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    `CMP({gain, mode, valid, rdrv, roe, il_q}, 10'h20C)
    burst(1'b0, 1'b1);
    foreach (gt[i]) begin
      u_host.write_word({4'h4, gt[i]});
      `CMP(gain, gt[i])
    end
    u_host.write_word(8'h58);
    `CMP({rdrv, roe, gain}, 6'h18)
    foreach (mw[i]) begin
      u_host.write_word(mw[i]);
      `CMP(mode, me[i])
    end
    u_host.write_word(8'h48);
    `CMP({valid, rdrv}, 2'h1)
    n = 0;
    while (valid !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    `CMP(n >= 10 && n <= 20, 1'b1)
    u_host.write_word(8'h68);
    `CMP({il_q, gain}, 5'h18)
    burst(1'b1, 1'b0);
    `CMP({cpoe, nclk > 5}, 2'h1)
    `CMP(ovf, 1'b0)
    results();
  end
endmodule // ddac_front_tb
`default_nettype wire
